// >>> design/irrs_top.sv
// serial-bus slave that reads one 32-bit register per command
// What this block does
// - four command bytes follow; first byte bits 2..0 opcode, 100b reads.
// - third command byte bits 5..2 are the four byte enables.
// - third command byte bits 1..0 give register address bits 11..10.
// - fourth command byte gives register address bits 9..2, dword aligned.
// - device returns register bytes 3, 2, 1, 0; master then stops.
// - slave address is 38h with straps low; straps set low bits.
// - second byte bits 3..0 plus third byte bit 7 select port.
// - read command copies the register into an internal 32-bit buffer.
// - reading past four bytes repeats the buffer from byte 3.
// - repeated start may merge both packets; device accepts it.
`timescale 1ns/1ps
module irrs_top #(
  // identifier value is arbitrary
  parameter logic [31:0] P_IDENT_VALUE = 32'h5a5a_0001
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_ce,
  input  wire logic                         i_scl,
  input  wire logic                         i_sda,
  output logic                              o_sda_out,
  output logic                              o_sda_oe,
  input  wire logic [irrs_pkg::STRAP_W-1:0] i_addr_strap,
  output logic                              o_reg_rd_req,
  output logic [irrs_pkg::PORT_W-1:0]       o_reg_port,
  output logic [irrs_pkg::RADDR_W-1:0]      o_reg_addr,
  output logic [irrs_pkg::BE_W-1:0]         o_reg_be,
  input  wire logic [31:0]                  i_reg_rd_data,
  input  wire logic                         i_reg_rd_ack,
  output logic                              o_busy
);
  import irrs_pkg::*;

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  logic                 rst_meta_reg;
  logic                 rst_b;
  logic                 scl_s1_reg;
  logic                 scl_s2_reg;
  logic                 scl_d_reg;
  logic                 sda_s1_reg;
  logic                 sda_s2_reg;
  logic                 sda_d_reg;
  logic                 tgl_s1_reg;
  logic                 tgl_s2_reg;
  logic                 tgl_d_reg;
  logic [STRAP_W-1:0]   strap_s1_reg;
  logic [STRAP_W-1:0]   strap_s2_reg;
  logic [1:0]           strap_cnt_reg;
  logic [6:0]           slave_addr_reg;

  irrs_link_if lnk_bus ();
  irrs_bit_sampler u_sampler (
    .i_scl   (i_scl),
    .i_rst_b (rst_b),
    .i_sda   (i_sda),
    .lnk     (lnk_bus.link)
  );

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_b        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b        <= rst_meta_reg;
    end
  end
  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
      {tgl_s1_reg, tgl_s2_reg, tgl_d_reg} <= 3'h0;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
    end else if (i_ce) begin
      {scl_d_reg, scl_s2_reg, scl_s1_reg} <= {scl_s2_reg, scl_s1_reg, i_scl};
      {sda_d_reg, sda_s2_reg, sda_s1_reg} <= {sda_s2_reg, sda_s1_reg, i_sda};
      {tgl_d_reg, tgl_s2_reg, tgl_s1_reg} <=
        {tgl_s2_reg, tgl_s1_reg, lnk_bus.bit_tgl};
      strap_s1_reg <= i_addr_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // straps are caught once, after the synchroniser has filled
  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt_reg  <= '0;
      slave_addr_reg <= ADDR_BASE;
    end else if (i_ce && strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == STRAP_CAP_CNT) begin
        slave_addr_reg <= {ADDR_BASE[6:STRAP_W], strap_s2_reg};
      end
    end
  end

  // ****************************************************************
  // bus events
  // ****************************************************************
  wire start_evt = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_evt  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  wire fall_evt  = scl_d_reg & ~scl_s2_reg;
  // bit value is held in the link domain until the next clock rise
  wire rise_evt  = tgl_s2_reg ^ tgl_d_reg;
  wire rx_bit    = lnk_bus.bit_val;

  // ****************************************************************
  // protocol state
  // ****************************************************************
  irrs_state_type  state_reg;
  logic [2:0]      bit_cnt_reg;
  logic            got_byte_reg;
  logic            is_addr_reg;
  logic            cmd_done_reg;
  logic            launch_reg;
  logic            mack_reg;
  logic [1:0]      cmd_idx_reg;
  logic [1:0]      byte_idx_reg;
  logic [7:0]      shift_reg;
  logic [7:0]      tx_shift_reg;
  logic [7:0]      cmd_reg [NUM_CMD];
  logic            sda_oe_reg;
  logic            sda_out_reg;
  logic [31:0]     buf_reg;
  logic            pend_reg;
  logic            rd_req_reg;
  logic [PORT_W-1:0]  port_reg;
  logic [RADDR_W-1:0] addr_reg;
  logic [BE_W-1:0]    be_reg;
  wire       addr_match = shift_reg[7:1] == slave_addr_reg;
  wire       take_byte  = is_addr_reg ? addr_match : !cmd_done_reg;
  // first byte of a packet is byte 3; after an ack the next one
  wire [1:0] tx_idx     = (state_reg == ST_TX_ACK) ?
                          byte_idx_reg + 2'h1 : 2'h0;
  wire [7:0] tx_byte    = buf_reg[{2'h3 - tx_idx, 3'h0} +: 8];
  wire       read_cmd   = cmd_reg[0][OPC_MSB:0] == OPC_READ;
  wire [PORT_W-1:0]  cmd_port = {cmd_reg[1][PSEL_HI_MSB:0],
                                 cmd_reg[2][PSEL_LO_BIT]};
  wire [RADDR_W-1:0] cmd_addr = {cmd_reg[2][AHI_MSB:0],
                                 cmd_reg[3], 2'h0};
  wire [BE_W-1:0]    cmd_be   = cmd_reg[2][BE_MSB:BE_LSB];

  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= '0;
      got_byte_reg <= 1'b0;
      is_addr_reg  <= 1'b0;
      cmd_done_reg <= 1'b0;
      launch_reg   <= 1'b0;
      mack_reg     <= 1'b0;
      cmd_idx_reg  <= '0;
      byte_idx_reg <= '0;
      shift_reg    <= '0;
      tx_shift_reg <= '0;
      sda_oe_reg   <= 1'b0;
      for (int i = 0; i < NUM_CMD; i++) begin
        cmd_reg[i] <= '0;
      end
    end else if (i_ce) begin
      launch_reg <= 1'b0;
      if (stop_evt) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (start_evt) begin
        // repeated start keeps the command already taken
        state_reg    <= ST_RX;
        is_addr_reg  <= 1'b1;
        bit_cnt_reg  <= '0;
        got_byte_reg <= 1'b0;
        byte_idx_reg <= '0;
        sda_oe_reg   <= 1'b0;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (rise_evt) begin
              shift_reg    <= {shift_reg[6:0], rx_bit};
              bit_cnt_reg  <= bit_cnt_reg + 3'h1;
              got_byte_reg <= bit_cnt_reg == 3'h7;
            end else if (fall_evt && got_byte_reg) begin
              got_byte_reg <= 1'b0;
              sda_oe_reg   <= take_byte;
              state_reg    <= take_byte ? ST_ACK : ST_IDLE;
            end
          end
          ST_ACK: begin
            if (fall_evt) begin
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= '0;
              state_reg   <= ST_RX;
              if (is_addr_reg) begin
                is_addr_reg <= 1'b0;
                if (shift_reg[0]) begin
                  tx_shift_reg <= tx_byte;
                  byte_idx_reg <= tx_idx;
                  sda_oe_reg   <= ~tx_byte[7];
                  state_reg    <= ST_TX;
                end else begin
                  cmd_idx_reg  <= '0;
                  cmd_done_reg <= 1'b0;
                end
              end else begin
                cmd_reg[cmd_idx_reg] <= shift_reg;
                cmd_idx_reg          <= cmd_idx_reg + 2'h1;
                cmd_done_reg         <= cmd_idx_reg == 2'h3;
                launch_reg           <= cmd_idx_reg == 2'h3;
              end
            end
          end
          ST_TX: begin
            if (fall_evt) begin
              if (bit_cnt_reg == 3'h7) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ST_TX_ACK;
              end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                sda_oe_reg   <= ~tx_shift_reg[6];
                bit_cnt_reg  <= bit_cnt_reg + 3'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (rise_evt) begin
              mack_reg <= ~rx_bit;
            end else if (fall_evt) begin
              bit_cnt_reg <= '0;
              if (mack_reg) begin
                // index wraps from 3 to 0: byte 3 follows byte 0
                tx_shift_reg <= tx_byte;
                byte_idx_reg <= tx_idx;
                sda_oe_reg   <= ~tx_byte[7];
                state_reg    <= ST_TX;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // register fetch into the read buffer
  // ****************************************************************
  wire ident_hit = cmd_addr == SSIP_OFFSET;
  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_reg     <= BUF_RST;
      pend_reg    <= 1'b0;
      rd_req_reg  <= 1'b0;
      port_reg    <= '0;
      addr_reg    <= '0;
      be_reg      <= '0;
      sda_out_reg <= 1'b0;
    end else if (i_ce) begin
      rd_req_reg <= 1'b0;
      if (launch_reg && read_cmd) begin
        port_reg <= cmd_port;
        addr_reg <= cmd_addr;
        be_reg   <= cmd_be;
        if (ident_hit) begin
          buf_reg <= P_IDENT_VALUE;
        end else begin
          rd_req_reg <= 1'b1;
          pend_reg   <= 1'b1;
        end
      end else if (pend_reg && i_reg_rd_ack) begin
        buf_reg  <= i_reg_rd_data;
        pend_reg <= 1'b0;
      end
    end
  end

  assign o_sda_out    = sda_out_reg;
  assign o_sda_oe     = sda_oe_reg;
  assign o_reg_rd_req = rd_req_reg;
  assign o_reg_port   = port_reg;
  assign o_reg_addr   = addr_reg;
  assign o_reg_be     = be_reg;
  assign o_busy       = pend_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_b);
  // the capture edge itself moves the address, so skip that first cycle
  a_strap_addr: assert property (strap_cnt_reg == 2'h3 &&
    $past(strap_cnt_reg) == 2'h3 |->
    slave_addr_reg[6:STRAP_W] == ADDR_BASE[6:STRAP_W] &&
    $stable(slave_addr_reg))
    else $error("slave address high bits wrong or moving");
  a_addr_ack: assert property (i_ce && !start_evt && !stop_evt &&
    state_reg == ST_RX && is_addr_reg && got_byte_reg && fall_evt &&
    addr_match |=> state_reg == ST_ACK && sda_oe_reg)
    else $error("matching address not acknowledged");
  a_opcode_gate: assert property (i_ce && launch_reg && !read_cmd
    |=> !rd_req_reg && !pend_reg)
    else $error("non-read opcode started a fetch");
  a_port_sel: assert property (rd_req_reg |->
    o_reg_port == {cmd_reg[1][3:0], cmd_reg[2][7]})
    else $error("port select wrong");
  a_be_field: assert property (rd_req_reg |->
    o_reg_be == cmd_reg[2][5:2])
    else $error("byte enables wrong");
  a_addr_high: assert property (rd_req_reg |->
    o_reg_addr[11:10] == cmd_reg[2][1:0])
    else $error("address bits 11..10 wrong");
  a_addr_low: assert property (rd_req_reg |->
    o_reg_addr[9:0] == {cmd_reg[3], 2'h0})
    else $error("address bits 9..0 wrong");
  a_buf_load: assert property (i_ce && pend_reg && i_reg_rd_ack &&
    !launch_reg |=> buf_reg == $past(i_reg_rd_data) && !pend_reg)
    else $error("read data not buffered");
  a_first_byte: assert property ($past(state_reg) == ST_ACK &&
    state_reg == ST_TX && $stable(buf_reg) |->
    tx_shift_reg == buf_reg[31:24] && byte_idx_reg == 2'h0)
    else $error("read packet does not open with byte 3");
  a_byte_wrap: assert property ($past(state_reg) == ST_TX_ACK &&
    state_reg == ST_TX && $past(byte_idx_reg) == 2'h3 |->
    byte_idx_reg == 2'h0)
    else $error("byte order does not restart at byte 3");
  a_restart: assert property (i_ce && start_evt |=>
    state_reg == ST_RX && is_addr_reg && bit_cnt_reg == 3'h0)
    else $error("start not taken as new address");

endmodule : irrs_top

// >>> design/irrs_pkg.sv
// shared constants and types of the register-read serial slave
package irrs_pkg;

  // ****************************************************************
  // slave address
  // ****************************************************************
  localparam int          STRAP_W       = 3;
  localparam logic [6:0]  ADDR_BASE     = 7'h38;

  // ****************************************************************
  // command byte fields
  // ****************************************************************
  localparam logic [2:0]  OPC_READ      = 3'h4;
  localparam int          OPC_MSB       = 2;
  localparam int          PSEL_HI_MSB   = 3;
  localparam int          PSEL_LO_BIT   = 7;
  localparam int          BE_MSB        = 5;
  localparam int          BE_LSB        = 2;
  localparam int          AHI_MSB       = 1;
  localparam int          PORT_W        = 5;
  localparam int          BE_W          = 4;
  localparam int          RADDR_W       = 12;
  localparam int          NUM_CMD       = 4;

  // ****************************************************************
  // registers and reset values
  // ****************************************************************
  localparam logic [11:0] SSIP_OFFSET   = 12'h0f8;
  localparam logic [31:0] BUF_RST       = 32'h0000_0000;
  localparam logic [1:0]  STRAP_CAP_CNT = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TX_ACK
  } irrs_state_type;

endpackage : irrs_pkg

// >>> design/irrs_link_if.sv
// carrier of sampled serial bits from the link clock domain
`timescale 1ns/1ps
interface irrs_link_if;
  logic bit_val;
  logic bit_tgl;

  modport link (output bit_val, output bit_tgl);
  modport core (input bit_val, input bit_tgl);
endinterface : irrs_link_if

// >>> design/irrs_bit_sampler.sv
// serial-clock domain: catches each data bit on the rising clock edge
`timescale 1ns/1ps
module irrs_bit_sampler (
  input  wire logic  i_scl,
  input  wire logic  i_rst_b,
  input  wire logic  i_sda,
  irrs_link_if.link  lnk
);
  import irrs_pkg::*;

  logic bit_reg;
  logic tgl_reg;

  // data is stable around this edge by protocol, so no synchroniser here;
  // the toggle tells the core domain that a fresh bit is held
  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_reg <= 1'b0;
      tgl_reg <= 1'b0;
    end else begin
      bit_reg <= i_sda;
      tgl_reg <= ~tgl_reg;
    end
  end

  assign lnk.bit_val = bit_reg;
  assign lnk.bit_tgl = tgl_reg;

endmodule : irrs_bit_sampler

// >>> tb/irrs_master_model.sv
// behavioural serial-bus master driving clock and open-drain data
`timescale 1ns/1ps
module irrs_master_model #(
  parameter int P_HALF = 24
) (
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  // ****************************************************************
  // bus phases
  // ****************************************************************
  // the clock stands high between frames; data moves only mid-low
  // so the slave never mistakes a bit edge for a start or stop
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic start();
    #(P_HALF/2);
    o_sda_low = 1'b0;
    #(P_HALF/2);
    o_scl = 1'b1;
    #P_HALF;
    o_sda_low = 1'b1;
    #P_HALF;
    o_scl = 1'b0;
  endtask : start

  task automatic stop();
    #(P_HALF/2);
    o_sda_low = 1'b1;
    #(P_HALF/2);
    o_scl = 1'b1;
    #P_HALF;
    o_sda_low = 1'b0;
    #P_HALF;
  endtask : stop

  task automatic bit_io(input logic b, output logic s);
    #(P_HALF/2);
    o_sda_low = !b;
    #(P_HALF/2);
    o_scl = 1'b1;
    #(P_HALF-8);
    s = i_sda;
    #8;
    o_scl = 1'b0;
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte

  // last byte is left unacknowledged so the slave lets go
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : rd_byte
endmodule : irrs_master_model

// >>> tb/testbench.sv
// self-checking bench of the register-read serial slave
`timescale 1ns/1ps
module testbench;
  import irrs_pkg::*;
  // identifier value is arbitrary
  localparam logic [31:0] IDENT = 32'ha1b2_c3d4;

  logic        i_ref_clk;
  logic        i_rst_b = 1'b0;
  logic        i_ce    = 1'b1;
  logic        scl;
  logic        m_low;
  wire         sda;
  logic        o_sda_out;
  logic        o_sda_oe;
  logic [2:0]  strap   = 3'h0;
  logic        req;
  logic [4:0]  port;
  logic [11:0] addr;
  logic [3:0]  be;
  logic [31:0] rdata   = 32'h0000_0000;
  logic [31:0] resp    = 32'h0000_0000;
  logic        rack    = 1'b0;
  logic        busy;
  int          fails, num_checks, ncyc, nreq, rsp_dly, cnt;

  // pulled-up open-drain wire
  assign sda = (m_low || (o_sda_oe && !o_sda_out)) ? 1'b0 : 1'b1;

  irrs_top #(.P_IDENT_VALUE(IDENT)) irrs_top_i (
    .i_ref_clk     (i_ref_clk),
    .i_rst_b       (i_rst_b),
    .i_ce          (i_ce),
    .i_scl         (scl),
    .i_sda         (sda),
    .o_sda_out     (o_sda_out),
    .o_sda_oe      (o_sda_oe),
    .i_addr_strap  (strap),
    .o_reg_rd_req  (req),
    .o_reg_port    (port),
    .o_reg_addr    (addr),
    .o_reg_be      (be),
    .i_reg_rd_data (rdata),
    .i_reg_rd_ack  (rack),
    .o_busy        (busy)
  );

  irrs_master_model irrs_master_model_i (
    .o_scl     (scl),
    .o_sda_low (m_low),
    .i_sda     (sda)
  );

  // ****************************************************************
  // clock, register responder, timeout
  // ****************************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  always @(negedge i_ref_clk) begin
    ncyc++;
    if (ncyc == 60000) begin
      fails++;
      summarize();
    end else begin
      if (req) begin
        nreq++;
        cnt = rsp_dly + 1;
      end
      rack  <= (cnt == 1);
      rdata <= resp;
      if (cnt > 0) cnt--;
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] b, input logic exp_ack,
                      input string what);
    logic a;
    irrs_master_model_i.wr_byte(b, a);
    chk({31'h0, a}, {31'h0, exp_ack}, what);
  endtask : send

  task automatic cmd(input logic [7:0] b0, b1, b2, b3,
                     input logic do_stop);
    logic [7:0] c[4];
    c = '{b0, b1, b2, b3};
    irrs_master_model_i.start();
    send(8'h70, 1'b1, "write address");
    for (int i = 0; i < 4; i++) begin
      send(c[i], 1'b1, "command byte");
    end
    if (do_stop) irrs_master_model_i.stop();
  endtask : cmd

  task automatic rdpkt(input logic [31:0] exp, input int n);
    logic [7:0] b;
    irrs_master_model_i.start();
    send(8'h71, 1'b1, "read address");
    for (int i = 0; i < n; i++) begin
      irrs_master_model_i.rd_byte(i == n - 1, b);
      chk({24'h0, b}, (exp >> (8 * (3 - i % 4))) & 32'hff, "data");
    end
    irrs_master_model_i.stop();
  endtask : rdpkt

  task automatic do_reset();
    i_rst_b = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    chk({29'h0, busy, req, o_sda_oe}, 32'h0, "outputs in reset");
    i_rst_b = 1'b1;
    repeat (20) @(negedge i_ref_clk);
  endtask : do_reset

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_ident();
    int n0;
    n0 = nreq;
    cmd(8'h04, 8'h00, 8'h3c, 8'h3e, 1'b1);
    rdpkt(IDENT, 4);
    chk(nreq - n0, 0, "identifier served inside");
  endtask : t_ident

  // merged packets, slow register answer, read past four bytes
  task automatic t_port();
    int n0;
    n0 = nreq;
    rsp_dly = 20;
    resp = 32'h1122_3344;
    cmd(8'h04, 8'h09, 8'hbf, 8'hff, 1'b0);
    // no stop here, so give the launch time to reach the outputs
    repeat (8) @(negedge i_ref_clk);
    chk({27'h0, port}, 32'h13, "port select");
    chk({20'h0, addr}, 32'hffc, "register address");
    chk({28'h0, be}, 32'hf, "byte enables");
    rdpkt(resp, 6);
    chk(nreq - n0, 1, "one fetch");
  endtask : t_port

  // partial enables are forwarded but never mask the data
  task automatic t_be();
    rsp_dly = 0;
    resp = 32'hcafe_0f5a;
    cmd(8'h04, 8'h00, 8'h14, 8'h01, 1'b1);
    chk({28'h0, be}, 32'h5, "byte enables");
    chk({20'h0, addr}, 32'h004, "register address");
    chk({27'h0, port}, 32'h0, "port select");
    rdpkt(resp, 4);
  endtask : t_be

  task automatic t_refuse();
    int n0;
    n0 = nreq;
    irrs_master_model_i.start();
    send(8'h72, 1'b0, "foreign address");
    irrs_master_model_i.stop();
    cmd(8'h03, 8'h00, 8'h3c, 8'h3e, 1'b0);
    send(8'h00, 1'b0, "fifth command byte");
    irrs_master_model_i.stop();
    chk(nreq - n0, 0, "no fetch on other opcode");
    rdpkt(32'hcafe_0f5a, 4);
  endtask : t_refuse

  task automatic t_strap();
    @(negedge i_ref_clk);
    strap = 3'h5;
    do_reset();
    irrs_master_model_i.start();
    send(8'h70, 1'b0, "base address with straps");
    irrs_master_model_i.stop();
    irrs_master_model_i.start();
    send(8'h7a, 1'b1, "strapped address");
    irrs_master_model_i.stop();
  endtask : t_strap

  initial begin
    do_reset();
    t_ident();
    t_port();
    t_be();
    t_refuse();
    t_strap();
    summarize();
  end
endmodule : testbench
